/* logic/betu_pkg.sv */
// package of constants and types for the bus event trigger unit
package betu_pkg;

  // ----------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_GP_COUNT = 8'h08;
  localparam logic [7:0] ADDR_U1_BASE = 8'h10;
  localparam logic [7:0] ADDR_U2_BASE = 8'h30;
  // per-unit word offsets from the unit base
  localparam logic [7:0] OFS_ADDR_CMP = 8'h00;
  localparam logic [7:0] OFS_DATA_CMP = 8'h04;
  localparam logic [7:0] OFS_PROBE = 8'h08;
  localparam logic [7:0] OFS_BUSOP = 8'h0C;
  localparam logic [7:0] OFS_PASS = 8'h10;
  localparam logic [7:0] OFS_DELAY = 8'h14;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  // compare word: value [15:0], operator [17:16]
  localparam int CMP_OP_LSB = 16;
  // probe word: pattern [7:0], care mask [15:8] (1 = compared)
  localparam int PROBE_CARE_LSB = 8;
  // control: mode [1:0], clear-all strobe [4], gp clear strobe [5]
  localparam int CTRL_CLEAR_BIT = 4;
  localparam int CTRL_GP_CLR_BIT = 5;

  // ----------------------------------------
  // widths and limits
  // ----------------------------------------
  localparam int VAL_W = 16;
  localparam logic [15:0] GP_MAX = 16'hFFFE;
  localparam logic [3:0] BUSOP_RESET = 4'h9;

  // ----------------------------------------
  // enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    BETU_OP_WORD_EQ = 2'h0,
    BETU_OP_BYTE_EQ = 2'h1,
    BETU_OP_LESS_EQ = 2'h2,
    BETU_OP_GREATER_EQ = 2'h3
  } betu_cmp_op_t;

  typedef enum logic [1:0] {
    BETU_MODE_SEPARATE = 2'h0,
    BETU_MODE_CHAINED = 2'h1,
    BETU_MODE_COINCIDENCE = 2'h2
  } betu_mode_t;

  typedef enum logic [3:0] {
    BETU_BUS_FETCH = 4'h0,
    BETU_BUS_IO = 4'h1,
    BETU_BUS_MEM = 4'h2,
    BETU_BUS_READ = 4'h3,
    BETU_BUS_WRITE = 4'h4,
    BETU_BUS_IO_READ = 4'h5,
    BETU_BUS_IO_WRITE = 4'h6,
    BETU_BUS_MEM_READ = 4'h7,
    BETU_BUS_MEM_WRITE = 4'h8,
    BETU_BUS_ALL = 4'h9
  } betu_busop_t;

endpackage

/* logic/betu_trigger_unit.sv */
// two-unit bus event trigger block with apb register access
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// R1 - less-than operator matches value at or below
// R2 - greater-than operator matches value at or above
// R3 - byte equality compares low eight bits only
// R4 - word equality compares all sixteen bits
// R5 - compare values held as sixteen bits
// R6 - probe bit n is channel n
// R7 - per-bit care mask, all masked removes probe
// R8 - bus qualifier picks one of ten classes
// R9 - other transaction classes are ignored
// R10 - bus qualifier resets to all class
// R11 - counters idle until all conditions match
// R12 - pass counts down per match, then delay
// R13 - pass count zero or one means none
// R14 - delay starts after pass, counts units
// R15 - delay of zero skips the delay stage
// R16 - counters to 65535, general counter saturates 65534
// R17 - each unit drives its own trigger output
// R18 - triggers never halt nor freeze anything
// R19 - only one relationship mode at once
// R20 - chained: one arms two, two rearms one
// R21 - chained: general counter runs between triggers
// R22 - chained: unit one delay not started
// R23 - coincidence: unit two address and class gate one
// R24 - mode defaults to separate on reset and clear
// R25 - evaluate once per bus transaction strobe
module betu_trigger_unit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // monitored target bus
  input wire logic i_bus_strobe,
  input wire logic [15:0] i_bus_addr,
  input wire logic [15:0] i_bus_data,
  input wire logic [7:0] i_probe,
  input wire logic i_bus_fetch,
  input wire logic i_bus_io,
  input wire logic i_bus_write,
  // count unit enable pulse
  input wire logic i_count_unit,
  // trigger outputs
  output logic o_unit_one_trigger_output,
  output logic o_unit_two_trigger_output
);

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // address or data compare under the selected operator
  function automatic logic cmp_match(input logic [15:0] bus_val, input logic [17:0] cfg);
    logic [15:0] ref_val;
    ref_val = cfg[15:0];
    case (betu_pkg::betu_cmp_op_t'(cfg[17:16]))
      betu_pkg::BETU_OP_BYTE_EQ: cmp_match = (bus_val[7:0] == ref_val[7:0]); // R3
      betu_pkg::BETU_OP_LESS_EQ: cmp_match = (bus_val <= ref_val); // R1
      betu_pkg::BETU_OP_GREATER_EQ: cmp_match = (bus_val >= ref_val); // R2
      default: cmp_match = (bus_val == ref_val); // R4
    endcase
  endfunction

  // bus class qualifier
  function automatic logic class_match(input logic [3:0] sel, input logic fetch, input logic io,
                                       input logic wr);
    case (betu_pkg::betu_busop_t'(sel)) // R8
      betu_pkg::BETU_BUS_FETCH: class_match = fetch;
      betu_pkg::BETU_BUS_IO: class_match = io;
      betu_pkg::BETU_BUS_MEM: class_match = !io;
      betu_pkg::BETU_BUS_READ: class_match = !wr;
      betu_pkg::BETU_BUS_WRITE: class_match = wr;
      betu_pkg::BETU_BUS_IO_READ: class_match = io && !wr;
      betu_pkg::BETU_BUS_IO_WRITE: class_match = io && wr;
      betu_pkg::BETU_BUS_MEM_READ: class_match = !io && !wr;
      betu_pkg::BETU_BUS_MEM_WRITE: class_match = !io && wr;
      default: class_match = 1'b1;
    endcase
  endfunction

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [17:0] addr_cfg [2];
  logic [17:0] data_cfg [2];
  logic [15:0] probe_cfg [2];
  logic [3:0] busop_cfg [2];
  logic [15:0] pass_cfg [2];
  logic [15:0] delay_cfg [2];
  logic [1:0] mode; // R19
  logic [15:0] gp_count;
  logic gp_running;
  logic armed_two;
  logic [1:0] fire;
  logic [1:0] delay_busy;

  logic wr_en;
  logic clear_all;
  logic gp_clear;
  logic [1:0] unit_sel;
  logic [7:0] unit_ofs;
  logic chained;
  logic coincident;

  assign wr_en = i_psel && i_penable && i_pwrite;
  assign clear_all = wr_en && (i_paddr == betu_pkg::ADDR_CTRL) && i_pwdata[betu_pkg::CTRL_CLEAR_BIT];
  assign gp_clear = wr_en && (i_paddr == betu_pkg::ADDR_CTRL) && i_pwdata[betu_pkg::CTRL_GP_CLR_BIT];
  assign unit_sel[0] = (i_paddr >= betu_pkg::ADDR_U1_BASE) && (i_paddr < betu_pkg::ADDR_U2_BASE);
  assign unit_sel[1] = (i_paddr >= betu_pkg::ADDR_U2_BASE) && (i_paddr < 8'h48);
  assign unit_ofs = unit_sel[1] ? (i_paddr - betu_pkg::ADDR_U2_BASE) : (i_paddr - betu_pkg::ADDR_U1_BASE);
  assign chained = (mode == betu_pkg::BETU_MODE_CHAINED);
  assign coincident = (mode == betu_pkg::BETU_MODE_COINCIDENCE);

  // always ready: zero wait states keep the master simple
  assign o_pready = 1'b1;
  assign o_pslverr = 1'b0;

  // mode register, cleared to separate on reset or clear-all
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mode <= betu_pkg::BETU_MODE_SEPARATE; // R24
    end else if (clear_all) begin
      mode <= betu_pkg::BETU_MODE_SEPARATE; // R24
    end else if (wr_en && (i_paddr == betu_pkg::ADDR_CTRL)) begin
      // unknown code falls back to separate so one mode always holds
      mode <= (i_pwdata[1:0] == 2'h3) ? betu_pkg::BETU_MODE_SEPARATE : i_pwdata[1:0]; // R19
    end
  end

  // ----------------------------------------
  // per-unit logic
  // ----------------------------------------
  logic [1:0] raw_match;
  logic [1:0] addr_class_match;
  logic [1:0] qual_match;
  logic [1:0] pass_done;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_unit
      logic [15:0] pass_left;
      logic [15:0] delay_left;
      logic [7:0] care;
      logic probe_ok;
      logic delay_enabled;

      // per-unit settings; a clear leaves the bus qualifier alone
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          addr_cfg[gi] <= 18'h00000;
          data_cfg[gi] <= 18'h00000;
          probe_cfg[gi] <= 16'h0000;
          busop_cfg[gi] <= betu_pkg::BUSOP_RESET; // R10
          pass_cfg[gi] <= 16'h0000;
          delay_cfg[gi] <= 16'h0000;
        end else if (clear_all) begin
          addr_cfg[gi] <= 18'h00000;
          data_cfg[gi] <= 18'h00000;
          probe_cfg[gi] <= 16'h0000;
          pass_cfg[gi] <= 16'h0000;
          delay_cfg[gi] <= 16'h0000;
        end else if (wr_en && unit_sel[gi]) begin
          case (unit_ofs)
            betu_pkg::OFS_ADDR_CMP: addr_cfg[gi] <= i_pwdata[17:0]; // R5
            betu_pkg::OFS_DATA_CMP: data_cfg[gi] <= i_pwdata[17:0]; // R5
            betu_pkg::OFS_PROBE: probe_cfg[gi] <= i_pwdata[15:0];
            betu_pkg::OFS_BUSOP: busop_cfg[gi] <= (i_pwdata[3:0] > 4'h9) ? betu_pkg::BUSOP_RESET : i_pwdata[3:0];
            betu_pkg::OFS_PASS: pass_cfg[gi] <= i_pwdata[15:0]; // R16
            betu_pkg::OFS_DELAY: delay_cfg[gi] <= i_pwdata[15:0]; // R16
            default: begin
            end
          endcase
        end
      end

      // probe compare: care mask of zero drops the term
      assign care = probe_cfg[gi][15:8];
      assign probe_ok = ((i_probe & care) == (probe_cfg[gi][7:0] & care)); // R6 R7
      assign addr_class_match[gi] = i_bus_strobe && class_match(busop_cfg[gi], i_bus_fetch, i_bus_io, i_bus_write) // R9
                                    && cmp_match(i_bus_addr, addr_cfg[gi]);
      assign raw_match[gi] = addr_class_match[gi] && cmp_match(i_bus_data, data_cfg[gi]) && probe_ok; // R25
      // chained mode keeps unit one's delay disabled, so unit one fires on pass completion, no delay there
      assign delay_enabled = (delay_cfg[gi] != 16'h0000) && !(gi == 0 && chained); // R15 R22
      assign pass_done[gi] = qual_match[gi] && (pass_left <= 16'h0001); // R13

      // pass counter, reloaded from setting at pass completion, holds between matches
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          pass_left <= 16'h0000;
        end else if (clear_all || (wr_en && unit_sel[gi] && unit_ofs == betu_pkg::OFS_PASS)) begin
          pass_left <= clear_all ? 16'h0000 : i_pwdata[15:0];
        end else if (pass_done[gi]) begin
          pass_left <= pass_cfg[gi];
        end else if (qual_match[gi]) begin
          pass_left <= pass_left - 16'h0001; // R12
        end
      end

      // delay counter, ticks on count unit pulses
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          delay_busy[gi] <= 1'b0;
          delay_left <= 16'h0000;
        end else if (clear_all) begin
          delay_busy[gi] <= 1'b0;
          delay_left <= 16'h0000;
        end else if (!delay_busy[gi] && pass_done[gi] && delay_enabled) begin
          delay_busy[gi] <= 1'b1; // R14
          delay_left <= delay_cfg[gi];
        end else if (delay_busy[gi] && i_count_unit) begin
          delay_left <= delay_left - 16'h0001;
          if (delay_left == 16'h0001) begin
            delay_busy[gi] <= 1'b0;
          end
        end
      end

      // fire on pass completion without delay, or at delay expiry
      assign fire[gi] = (pass_done[gi] && !delay_enabled && !delay_busy[gi]) // R11 R17
                        || (delay_busy[gi] && i_count_unit && delay_left == 16'h0001);
    end
  endgenerate

  // qualified matches per mode; idle counters until full match
  assign qual_match[0] = raw_match[0] && (!coincident || addr_class_match[1]) && !(chained && armed_two); // R11 R23
  assign qual_match[1] = raw_match[1] && (!chained || armed_two); // R20

  // chained arming: one arms two, two rearms one
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      armed_two <= 1'b0;
    end else if (!chained || clear_all) begin
      armed_two <= 1'b0;
    end else if (fire[1] && armed_two) begin
      armed_two <= 1'b0; // R20
    end else if (fire[0]) begin
      armed_two <= 1'b1; // R20
    end
  end

  // general purpose counter between the two chained triggers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      gp_running <= 1'b0;
      gp_count <= 16'h0000;
    end else if (clear_all) begin
      gp_running <= 1'b0;
      gp_count <= 16'h0000;
    end else if (chained && fire[0] && !armed_two) begin
      // a start in the same cycle as a gp clear strobe wins, so no window is lost
      gp_running <= 1'b1; // R21
      gp_count <= 16'h0000;
    end else if (gp_clear) begin
      gp_running <= 1'b0;
      gp_count <= 16'h0000;
    end else if (chained && fire[1] && armed_two) begin
      gp_running <= 1'b0; // R21
    end else if (gp_running && i_count_unit && gp_count < betu_pkg::GP_MAX) begin
      gp_count <= gp_count + 16'h0001; // R16
    end
  end

  // trigger outputs: one-cycle pulses, nothing else is touched by them
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_unit_one_trigger_output <= 1'b0;
      o_unit_two_trigger_output <= 1'b0;
    end else begin
      o_unit_one_trigger_output <= fire[0]; // R17 R18
      o_unit_two_trigger_output <= fire[1]; // R17 R18
    end
  end

  // ----------------------------------------
  // apb read mux
  // ----------------------------------------
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable && !i_pwrite) begin
      o_prdata <= 32'h00000000;
      if (i_paddr == betu_pkg::ADDR_CTRL) begin
        o_prdata <= {30'h0, mode};
      end else if (i_paddr == betu_pkg::ADDR_STATUS) begin
        o_prdata <= {26'h0, delay_busy, gp_running, armed_two, 2'h0};
      end else if (i_paddr == betu_pkg::ADDR_GP_COUNT) begin
        o_prdata <= {16'h0000, gp_count};
      end else if (unit_sel[0] || unit_sel[1]) begin
        case (unit_ofs)
          betu_pkg::OFS_ADDR_CMP: o_prdata <= {14'h0, addr_cfg[unit_sel[1]]};
          betu_pkg::OFS_DATA_CMP: o_prdata <= {14'h0, data_cfg[unit_sel[1]]};
          betu_pkg::OFS_PROBE: o_prdata <= {16'h0000, probe_cfg[unit_sel[1]]};
          betu_pkg::OFS_BUSOP: o_prdata <= {28'h0000000, busop_cfg[unit_sel[1]]};
          betu_pkg::OFS_PASS: o_prdata <= {16'h0000, pass_cfg[unit_sel[1]]};
          betu_pkg::OFS_DELAY: o_prdata <= {16'h0000, delay_cfg[unit_sel[1]]};
          default: o_prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_mode_legal;
    @(posedge i_clk) disable iff (i_reset) mode != 2'h3;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode"); // R19

  property p_clear_sep;
    @(posedge i_clk) disable iff (i_reset) clear_all |=> mode == betu_pkg::BETU_MODE_SEPARATE;
  endproperty
  a_clear_sep: assert property (p_clear_sep) else $error("clear did not restore separate mode"); // R24

  property p_trig_cause;
    @(posedge i_clk) disable iff (i_reset) o_unit_one_trigger_output |-> $past(fire[0]);
  endproperty
  a_trig_cause: assert property (p_trig_cause) else $error("trigger one without cause"); // R17

  property p_no_match_no_fire;
    @(posedge i_clk) disable iff (i_reset) (!i_bus_strobe && !delay_busy[1]) |-> !fire[1];
  endproperty
  a_no_match_no_fire: assert property (p_no_match_no_fire) else $error("fire without transaction"); // R25

  property p_two_needs_arm;
    @(posedge i_clk) disable iff (i_reset) (chained && !armed_two && !delay_busy[1]) |-> !fire[1];
  endproperty
  a_two_needs_arm: assert property (p_two_needs_arm) else $error("unit two fired unarmed"); // R20

  property p_arm_after_one;
    @(posedge i_clk) disable iff (i_reset) (chained && fire[0] && !clear_all) |=> armed_two;
  endproperty
  a_arm_after_one: assert property (p_arm_after_one) else $error("unit one did not arm two"); // R20

  property p_gp_sat;
    @(posedge i_clk) disable iff (i_reset) gp_count <= betu_pkg::GP_MAX;
  endproperty
  a_gp_sat: assert property (p_gp_sat) else $error("general counter above limit"); // R16

  property p_no_delay_chained;
    @(posedge i_clk) disable iff (i_reset) chained && !$past(delay_busy[0]) |-> !$rose(delay_busy[0]);
  endproperty
  a_no_delay_chained: assert property (p_no_delay_chained) else $error("unit one delay in chained mode"); // R22

  property p_coinc_gate;
    @(posedge i_clk) disable iff (i_reset) (coincident && !addr_class_match[1]) |-> !qual_match[0];
  endproperty
  a_coinc_gate: assert property (p_coinc_gate) else $error("coincidence gate ignored"); // R23

  // unit one steps: the last delay tick, or a direct hit, then the output pulse
  sequence s_one_delay_expires;
    delay_busy[0] && i_count_unit && (g_unit[0].delay_left == 16'h0001);
  endsequence

  sequence s_one_direct_hit;
    pass_done[0] && !g_unit[0].delay_enabled && !delay_busy[0];
  endsequence

  sequence s_one_pulses;
    o_unit_one_trigger_output;
  endsequence

  property p_delay_fires;
    @(posedge i_clk) disable iff (i_reset) s_one_delay_expires |=> s_one_pulses;
  endproperty
  a_delay_fires: assert property (p_delay_fires) else $error("delay expiry gave no trigger"); // R14

  property p_direct_fires;
    @(posedge i_clk) disable iff (i_reset) s_one_direct_hit |=> s_one_pulses;
  endproperty
  a_direct_fires: assert property (p_direct_fires) else $error("direct hit gave no trigger"); // R15

endmodule

/* verification/betu_bus_model.sv */
// target bus model that feeds transactions into the trigger block
`timescale 1ns/1ns
module betu_bus_model (
  // clock
  input wire logic i_clk,
  // target bus toward the block
  output logic o_strobe,
  output logic [15:0] o_addr,
  output logic [15:0] o_data,
  output logic [7:0] o_probe,
  output logic o_fetch,
  output logic o_io,
  output logic o_write
);
  // idle bus: no strobe, lines parked away from any value
  initial begin
    o_strobe = 1'b0;
    o_addr = 16'hFFFF;
    o_data = 16'hFFFF;
    o_probe = 8'hFF;
    o_fetch = 1'b0;
    o_io = 1'b0;
    o_write = 1'b0;
  end

  // one transaction; kind 0 fetch, 1 mem read, 2 mem write, 3 io read, 4 io write
  task automatic issue(input logic [15:0] a, input logic [15:0] d, input logic [7:0] p, input int k);
    @(posedge i_clk);
    o_strobe <= 1'b1;
    o_addr <= a;
    o_data <= d;
    o_probe <= p;
    o_fetch <= (k == 0);
    o_io <= (k >= 3);
    o_write <= (k == 2) || (k == 4);
    @(posedge i_clk);
    o_strobe <= 1'b0;
    // inverted leftovers, so a stale value never matches by luck
    o_addr <= ~a;
    o_data <= ~d;
    o_probe <= ~p;
  endtask
endmodule

/* verification/bus_event_trigger_unit_tb.sv */
// self-checking bench for the bus event trigger unit
`timescale 1ns/1ns
module bus_event_trigger_unit_tb;
  logic i_clk, i_reset, psel, pen, pwr, cu, stb, fe, io, wr, t1, t2, rdy, err;
  logic [7:0] paddr, pb, p, m, q;
  logic [15:0] ba, bd, a, v, d;
  logic [31:0] pwd, prd, rd, r;
  logic [1:0] op;
  int mismatches, n_checks, cyc, seed, i, j, kd;
  localparam logic [7:0] U1 = betu_pkg::ADDR_U1_BASE;
  localparam logic [7:0] U2 = betu_pkg::ADDR_U2_BASE;

  betu_trigger_unit dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(err), .i_bus_strobe(stb),
    .i_bus_addr(ba), .i_bus_data(bd), .i_probe(pb), .i_bus_fetch(fe), .i_bus_io(io), .i_bus_write(wr),
    .i_count_unit(cu), .o_unit_one_trigger_output(t1), .o_unit_two_trigger_output(t2));
  betu_bus_model bus_u (.i_clk(i_clk), .o_strobe(stb), .o_addr(ba), .o_data(bd), .o_probe(pb), .o_fetch(fe),
    .o_io(io), .o_write(wr));

  // 50 MHz clock
  initial i_clk = 1'b0;
  always #10 i_clk = ~i_clk;

  // hang guard: the whole run needs under a thousand cycles
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      stop_test();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // apb transfer; read data taken at the edge that sees pready
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge i_clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= ad;
    pwd <= wd;
    @(posedge i_clk);
    pen <= 1'b1;
    @(posedge i_clk);
    while (rdy !== 1'b1) @(posedge i_clk);
    rd = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic rchk(input string s, input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(s, rd, exp);
    chk("slave error", {31'h0, err}, 32'h0);
  endtask

  // both triggers looked at in the one cycle they stand; x skips unit two
  task automatic trig(input logic e1, input logic e2);
    #1;
    chk("unit one trigger", {31'h0, t1}, {31'h0, e1});
    if (e2 !== 1'bx) chk("unit two trigger", {31'h0, t2}, {31'h0, e2});
  endtask

  task automatic tx(input logic [15:0] ta, input int k, input logic e1, input logic e2);
    r = $random(seed);
    bus_u.issue(ta, r[15:0], r[23:16], k);
    trig(e1, e2);
  endtask

  task automatic pulse(input logic e1);
    @(posedge i_clk);
    cu <= 1'b1;
    @(posedge i_clk);
    cu <= 1'b0;
    trig(e1, 1'b0);
  endtask

  function automatic logic cmp(input logic [1:0] o, input logic [15:0] val, input logic [15:0] b);
    case (o)
      2'h0: return b == val;
      2'h1: return b[7:0] == val[7:0];
      2'h2: return b <= val;
      default: return b >= val;
    endcase
  endfunction

  // fetch counts as a memory read
  function automatic logic cls_ok(input int c, input int k);
    logic f, o, w;
    f = (k == 0);
    o = (k >= 3);
    w = (k == 2) || (k == 4);
    case (c)
      0: return f;
      1: return o;
      2: return !o;
      3: return !w;
      4: return w;
      5: return o && !w;
      6: return o && w;
      7: return !o && !w;
      8: return !o && w;
      default: return 1'b1;
    endcase
  endfunction

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hFFE3;
    {psel, pen, pwr, cu, cyc, mismatches, n_checks} = '0;
    paddr = 8'h00;
    pwd = 32'h0;
    i_reset = 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk("bus class", U1 + betu_pkg::OFS_BUSOP, 32'h9);
    rchk("mode", betu_pkg::ADDR_CTRL, 32'h0);
    rchk("unmapped", 8'hFC, 32'h0);
    $display("test reset done");
    // random compare values and operators, corner values first
    apb(1'b1, U1 + betu_pkg::OFS_DATA_CMP, 32'h30000);
    for (i = 0; i < 40; i++) begin
      r = $random(seed);
      op = (i < 4) ? i[1:0] : r[17:16];
      v = (i < 4) ? 16'h0075 : r[15:0];
      a = (i < 4) ? 16'h1275 : ((i % 3 == 0) ? v : r[31:16]);
      d = $random(seed);
      apb(1'b1, U1 + betu_pkg::OFS_ADDR_CMP, {14'h0, op, v});
      bus_u.issue(a, d, 8'h5A, i % 5);
      trig(cmp(op, v, a), (a == 16'h0) && (d == 16'h0));
    end
    apb(1'b1, U1 + betu_pkg::OFS_ADDR_CMP, 32'h3FFFF);
    rchk("addr compare", U1 + betu_pkg::OFS_ADDR_CMP, 32'h3FFFF);
    $display("test compare done");
    apb(1'b1, U1 + betu_pkg::OFS_ADDR_CMP, 32'h30000);
    for (i = 0; i < 30; i++) begin
      r = $random(seed);
      p = r[7:0];
      m = (i % 4 == 0) ? 8'h00 : r[15:8];
      q = (i % 3 == 0) ? p : r[23:16];
      apb(1'b1, U1 + betu_pkg::OFS_PROBE, {16'h0, m, p});
      bus_u.issue(r[31:16], 16'h1, q, 1);
      trig(((q ^ p) & m) == 8'h00, 1'bx);
    end
    apb(1'b1, U1 + betu_pkg::OFS_PROBE, 32'h0);
    $display("test probe done");
    for (i = 0; i < 10; i++) begin
      apb(1'b1, U1 + betu_pkg::OFS_BUSOP, i);
      for (kd = 0; kd < 5; kd++) tx(16'h4321, kd, cls_ok(i, kd), 1'bx);
    end
    $display("test class done");
    apb(1'b1, U1 + betu_pkg::OFS_ADDR_CMP, 32'h1234);
    for (i = 0; i < 4; i++) begin
      apb(1'b1, U1 + betu_pkg::OFS_PASS, i);
      for (j = 0; j < 6; j++) begin
        tx(16'h1235, 1, 1'b0, 1'bx);
        tx(16'h1234, 1, (i < 2) || ((j + 1) % i == 0), 1'bx);
      end
    end
    apb(1'b1, U1 + betu_pkg::OFS_PASS, 32'h0);
    apb(1'b1, U1 + betu_pkg::OFS_DELAY, 32'h3);
    tx(16'h1234, 0, 1'b0, 1'b0);
    for (i = 0; i < 3; i++) pulse(i == 2);
    apb(1'b1, U1 + betu_pkg::OFS_PASS, 32'h2);
    apb(1'b1, U1 + betu_pkg::OFS_DELAY, 32'h1);
    tx(16'h1234, 0, 1'b0, 1'b0);
    tx(16'h1234, 0, 1'b0, 1'b0);
    pulse(1'b1);
    $display("test counters done");
    // chained: no unit one delay is programmed here
    apb(1'b1, U1 + betu_pkg::OFS_PASS, 32'h0);
    apb(1'b1, U1 + betu_pkg::OFS_DELAY, 32'h0);
    apb(1'b1, U2 + betu_pkg::OFS_ADDR_CMP, 32'h0200);
    apb(1'b1, U2 + betu_pkg::OFS_DATA_CMP, 32'h30000);
    apb(1'b1, betu_pkg::ADDR_CTRL, 32'h21);
    tx(16'h0200, 1, 1'b0, 1'b0);
    tx(16'h1234, 1, 1'b1, 1'b0);
    tx(16'h1234, 1, 1'b0, 1'b0);
    for (i = 0; i < 5; i++) pulse(1'b0);
    tx(16'h0200, 1, 1'b0, 1'b1);
    pulse(1'b0);
    rchk("general counter", betu_pkg::ADDR_GP_COUNT, 32'h5);
    tx(16'h1234, 1, 1'b1, 1'b0);
    $display("test chained done");
    // coincidence: unit two data compare is left unmatchable on purpose
    apb(1'b1, U2 + betu_pkg::OFS_ADDR_CMP, 32'h20300);
    apb(1'b1, U2 + betu_pkg::OFS_DATA_CMP, 32'hABCD);
    apb(1'b1, U2 + betu_pkg::OFS_BUSOP, 32'h4);
    apb(1'b1, betu_pkg::ADDR_CTRL, 32'h2);
    tx(16'h1234, 2, 1'b0, 1'bx);
    apb(1'b1, U1 + betu_pkg::OFS_ADDR_CMP, 32'h20250);
    tx(16'h0200, 1, 1'b0, 1'bx);
    tx(16'h0200, 2, 1'b1, 1'bx);
    tx(16'h0280, 2, 1'b0, 1'bx);
    $display("test coincidence done");
    apb(1'b1, betu_pkg::ADDR_CTRL, 32'h10);
    rchk("mode", betu_pkg::ADDR_CTRL, 32'h0);
    rchk("addr compare", U1 + betu_pkg::OFS_ADDR_CMP, 32'h0);
    rchk("bus class", U2 + betu_pkg::OFS_BUSOP, 32'h4);
    $display("test clear done");
    // mid-run restart out of chained mode must fall back to separate
    apb(1'b1, betu_pkg::ADDR_CTRL, 32'h1);
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    rchk("mode", betu_pkg::ADDR_CTRL, 32'h0);
    rchk("bus class", U2 + betu_pkg::OFS_BUSOP, 32'h9);
    $display("test restart done");
    stop_test();
  end
endmodule
